// File: design/udci_cmd_input.sv
// command and control input stage of an unbuffered ddr4 module
// ----------------------------------------------------------------
// Functional notes
// (RULE1) all inputs are captured on the rising clock edge
// (RULE2) cke high runs clocks, buffers and drivers; low stops them
// (RULE3) cke low: idle banks give precharge power-down or self-refresh, open rows active power-down (here self-refresh entry ignores open rows)
// (RULE4) cke is sampled synchronously for self-refresh exit
// (RULE5) controller keeps cke high throughout reads and writes
// (RULE6) power-down keeps only clock, odt and cke buffers on
// (RULE7) self-refresh keeps only the cke buffer on
// (RULE8) cs high masks commands; cs selects the rank
// (RULE9) only two chip selects used; third, fourth and chip id unused
// (RULE10) registered odt enables nominal termination on dq, strobe and mask pins
// (RULE11) strobe-termination pins terminate only when mode register 1 bit 11 set
// (RULE12) odt ignored when mode register 1 disables nominal termination
// (RULE13) act low with cs low: activate, command pins are row bits 16..14
// (RULE14) act high: ras, cas, we with cs decode non-activate commands
// (RULE15) write beats with mask sampled low are discarded
// (RULE16) inversion low means data inverted, high means passed, both directions
// (RULE17) termination strobe function unused on this module
// (RULE18) bank group selects target group; bg0 helps pick the mode register
// (RULE19) bank address selects target bank; also helps pick the mode register
// (RULE20) a10 gives auto-precharge on read/write, all-bank close on precharge
// (RULE21) a12 low on read/write gives burst chop, high full burst
// (RULE22) reset pin low resets asynchronously; normal only while high (here the state resets through registered rst_q, two edges after the pin falls)
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module udci_cmd_input #(
	parameter int RANKS = udci_pkg::UDCI_RANKS_MAX,
	parameter int LANES = udci_pkg::UDCI_LANES,
	parameter bit TDQS_PRESENT = 1'b0
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic RESET_N,
	input wire logic [RANKS-1:0] CKE,
	input wire logic [RANKS-1:0] CS_N,
	input wire logic [RANKS-1:0] ODT,
	input wire udci_pkg::udci_ca_t CA,
	input wire logic DM_EN,
	input wire logic DBI_EN,
	input wire logic WR_VALID,
	input wire logic [8*LANES-1:0] WR_DQ,
	input wire logic [LANES-1:0] WR_DM_DBI_N,
	input wire logic RD_VALID,
	input wire logic [8*LANES-1:0] RD_DATA,
	input wire logic [LANES-1:0] RD_INV,
	output udci_pkg::udci_cmd_t CMD,
	output udci_pkg::udci_pwr_e_t [RANKS-1:0] PWR_STATE,
	output udci_pkg::udci_ibuf_t [RANKS-1:0] IBUF_EN,
	output logic [RANKS-1:0] CLK_RUN,
	output logic [RANKS-1:0] RTT_DQ_EN,
	output logic [RANKS-1:0] RTT_TDQS_EN,
	output logic [RANKS-1:0][udci_pkg::UDCI_BANKS-1:0] BANK_OPEN,
	output logic WR_OUT_VALID,
	output logic [8*LANES-1:0] WR_DATA,
	output logic [LANES-1:0] WR_BE,
	output logic RD_OUT_VALID,
	output logic [8*LANES-1:0] RD_DQ,
	output logic [LANES-1:0] RD_DBI_N
);
	// ----------------------------------------------------------------
	// decode of the non-activate command pins
	// ----------------------------------------------------------------
	function automatic udci_pkg::udci_cmd_e_t udci_decode(input logic [2:0] code);
		udci_pkg::udci_cmd_e_t op;
		unique case (code)
			udci_pkg::UDCI_OP_MRS: op = udci_pkg::UDCI_C_MRS;
			udci_pkg::UDCI_OP_REF: op = udci_pkg::UDCI_C_REF;
			udci_pkg::UDCI_OP_PRE: op = udci_pkg::UDCI_C_PRE;
			udci_pkg::UDCI_OP_RFU: op = udci_pkg::UDCI_C_RFU;
			udci_pkg::UDCI_OP_WR: op = udci_pkg::UDCI_C_WR;
			udci_pkg::UDCI_OP_RD: op = udci_pkg::UDCI_C_RD;
			udci_pkg::UDCI_OP_ZQ: op = udci_pkg::UDCI_C_ZQ;
			udci_pkg::UDCI_OP_NOP: op = udci_pkg::UDCI_C_NONE;
		endcase
		return op;
	endfunction

	if (RANKS < 1 || RANKS > udci_pkg::UDCI_RANKS_MAX) begin : g_bad
		$error("udci_cmd_input: only the first two chip selects exist");
	end

	// ----------------------------------------------------------------
	// reset: pin clears two sync flops at once, rst_q asserts at the next edge; release takes three edges
	// ----------------------------------------------------------------
	logic rstn_s1_q;
	logic rstn_s2_q;
	logic rst_q;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rstn_s1_q <= 1'b0; // RULE22
			rstn_s2_q <= 1'b0;
		end else begin
			rstn_s1_q <= 1'b1;
			rstn_s2_q <= rstn_s1_q;
		end
	end

	always_ff @(posedge CLK) begin
		rst_q <= SYS_RST | ~rstn_s2_q; // RULE22
	end

	// ----------------------------------------------------------------
	// capture stage
	// ----------------------------------------------------------------
	// the host drives these from the same clock, so one capture flop suffices
	logic [RANKS-1:0] cke_q;
	logic [RANKS-1:0] cke_prev_q;
	logic [RANKS-1:0] cs_n_q;
	logic [RANKS-1:0] odt_q;
	udci_pkg::udci_ca_t ca_q;

	always_ff @(posedge CLK) begin
		if (rst_q) begin
			cke_q <= '0;
			cke_prev_q <= '0;
			cs_n_q <= '1;
			odt_q <= '0;
			ca_q <= '1;
		end else begin
			cke_q <= CKE; // RULE1
			cke_prev_q <= cke_q;
			cs_n_q <= CS_N; // RULE1
			odt_q <= ODT;
			ca_q <= CA; // RULE1
		end
	end

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	wire logic any_sel = ~&cs_n_q; // RULE8
	wire logic rank_idx = cs_n_q[0] & (RANKS > 1); // RULE9
	wire logic is_act = ~ca_q.act_n; // RULE13
	wire udci_pkg::udci_cmd_e_t dec_op = udci_decode({ca_q.ras_n, ca_q.cas_n, ca_q.we_n}); // RULE14
	wire udci_pkg::udci_cmd_e_t cmd_op = is_act ? udci_pkg::UDCI_C_ACT : dec_op;
	wire logic is_rdwr = ~is_act & (dec_op == udci_pkg::UDCI_C_RD || dec_op == udci_pkg::UDCI_C_WR);
	wire logic is_pre = ~is_act & (dec_op == udci_pkg::UDCI_C_PRE);
	wire logic is_mrs = ~is_act & (dec_op == udci_pkg::UDCI_C_MRS);
	wire logic is_ref = ~is_act & (dec_op == udci_pkg::UDCI_C_REF);
	wire logic a10 = ca_q.addr[udci_pkg::UDCI_AP_BIT];
	wire logic a12 = ca_q.addr[udci_pkg::UDCI_BC_BIT];
	wire logic [3:0] bank_idx = {ca_q.bg, ca_q.ba}; // RULE18 RULE19
	wire logic [2:0] mr_sel = {ca_q.bg[0], ca_q.ba}; // RULE18 RULE19

	logic [RANKS-1:0] live;
	logic [RANKS-1:0] cke_fall;
	logic [RANKS-1:0] sre;
	udci_pkg::udci_pwr_e_t [RANKS-1:0] pwr_q;
	logic [RANKS-1:0][udci_pkg::UDCI_BANKS-1:0] open_q;
	logic [RANKS-1:0][udci_pkg::UDCI_ADDR_W-1:0] mr1_q;
	logic [RANKS-1:0] cmd_buf_on;

	// ----------------------------------------------------------------
	// per-rank power state, bank state and termination
	// ----------------------------------------------------------------
	for (genvar r = 0; r < RANKS; r++) begin : g_rank
		udci_pkg::udci_pwr_e_t pwr_d;
		logic [udci_pkg::UDCI_BANKS-1:0] open_d;
		wire logic hit = any_sel & (rank_idx == 1'(r)); // RULE8
		wire logic active = (pwr_q[r] == udci_pkg::UDCI_PS_ACTIVE);
		wire logic rtt_on = |mr1_q[r][udci_pkg::UDCI_MR1_RTT_HI:udci_pkg::UDCI_MR1_RTT_LO];
		wire logic in_sr = (pwr_q[r] == udci_pkg::UDCI_PS_SELF_REF);
		wire logic rtt_d = odt_q[r] & ~in_sr & rtt_on; // RULE10 RULE12 RULE7
		wire logic tdqs_d = rtt_d & mr1_q[r][udci_pkg::UDCI_MR1_TDQS_BIT] & TDQS_PRESENT; // RULE11 RULE17

		assign cke_fall[r] = cke_prev_q[r] & ~cke_q[r];
		assign live[r] = hit & cke_q[r] & active; // RULE2 RULE6 RULE7
		assign sre[r] = hit & cke_fall[r] & active & is_ref;
		assign cmd_buf_on[r] = active & cke_q[r];

		always_comb begin
			pwr_d = pwr_q[r];
			unique case (pwr_q[r])
				udci_pkg::UDCI_PS_ACTIVE: begin
					if (sre[r]) begin
						pwr_d = udci_pkg::UDCI_PS_SELF_REF; // RULE3
					end else if (cke_fall[r]) begin
						pwr_d = (|open_q[r]) ? udci_pkg::UDCI_PS_ACT_PD : udci_pkg::UDCI_PS_PRE_PD; // RULE3
					end
				end
				udci_pkg::UDCI_PS_PRE_PD, udci_pkg::UDCI_PS_ACT_PD: begin
					if (cke_q[r]) begin
						pwr_d = udci_pkg::UDCI_PS_ACTIVE; // RULE2
					end
				end
				udci_pkg::UDCI_PS_SELF_REF: begin
					if (cke_q[r]) begin
						pwr_d = udci_pkg::UDCI_PS_ACTIVE; // RULE4
					end
				end
			endcase
		end

		// auto-precharge closes the bank here; array timing is not modelled
		always_comb begin
			open_d = open_q[r];
			if (live[r] && is_act) begin
				open_d[bank_idx] = 1'b1;
			end else if (live[r] && is_pre) begin
				if (a10) begin
					open_d = '0; // RULE20
				end else begin
					open_d[bank_idx] = 1'b0;
				end
			end else if (live[r] && is_rdwr && a10) begin
				open_d[bank_idx] = 1'b0; // RULE20
			end
		end

		always_ff @(posedge CLK) begin
			if (rst_q) begin
				pwr_q[r] <= udci_pkg::UDCI_PS_ACTIVE;
				open_q[r] <= '0;
				mr1_q[r] <= udci_pkg::UDCI_MR1_RST;
				IBUF_EN[r] <= '1;
				CLK_RUN[r] <= 1'b0;
				RTT_DQ_EN[r] <= 1'b0;
				RTT_TDQS_EN[r] <= 1'b0;
			end else begin
				pwr_q[r] <= pwr_d;
				open_q[r] <= open_d;
				if (live[r] && is_mrs && mr_sel == udci_pkg::UDCI_MR1_SEL) begin
					mr1_q[r] <= ca_q.addr;
				end
				IBUF_EN[r].cke <= 1'b1;
				IBUF_EN[r].odt <= (pwr_d != udci_pkg::UDCI_PS_SELF_REF); // RULE6 RULE7
				IBUF_EN[r].ck <= (pwr_d != udci_pkg::UDCI_PS_SELF_REF); // RULE6 RULE7
				IBUF_EN[r].cmd <= (pwr_d == udci_pkg::UDCI_PS_ACTIVE); // RULE6
				CLK_RUN[r] <= (pwr_d == udci_pkg::UDCI_PS_ACTIVE) & cke_q[r]; // RULE2
				RTT_DQ_EN[r] <= rtt_d;
				RTT_TDQS_EN[r] <= tdqs_d;
			end
		end
	end

	assign PWR_STATE = pwr_q;
	assign BANK_OPEN = open_q;

	// ----------------------------------------------------------------
	// decoded command register
	// ----------------------------------------------------------------
	udci_pkg::udci_cmd_t cmd_d;
	wire logic cmd_live = live[rank_idx];

	always_comb begin
		cmd_d = '0;
		if (cmd_live) begin
			cmd_d.valid = 1'b1;
			cmd_d.op = cmd_op;
			cmd_d.rank = rank_idx;
			cmd_d.bg = ca_q.bg; // RULE18
			cmd_d.ba = ca_q.ba; // RULE19
			cmd_d.row = {ca_q.ras_n, ca_q.cas_n, ca_q.we_n, ca_q.addr}; // RULE13
			cmd_d.col = ca_q.addr[9:0];
			cmd_d.auto_pre = is_rdwr & a10; // RULE20
			cmd_d.burst_chop = is_rdwr & ~a12; // RULE21
			cmd_d.pre_all = is_pre & a10; // RULE20
			cmd_d.mr_sel = is_mrs ? mr_sel : 3'h0;
			cmd_d.opcode = ca_q.addr;
		end
	end

	always_ff @(posedge CLK) begin
		if (rst_q) begin
			CMD <= '0;
		end else begin
			CMD <= cmd_d; // RULE8
		end
	end

	// ----------------------------------------------------------------
	// data path; buffers and drivers follow the command buffer state
	// ----------------------------------------------------------------
	wire logic dq_on = |cmd_buf_on; // RULE2 RULE5

	udci_dq_lanes #(
		.LANES(LANES)
	) u_lanes (
		.clk(CLK),
		.rst(rst_q),
		.wr_valid(WR_VALID & dq_on),
		.dm_en(DM_EN),
		.dbi_en(DBI_EN),
		.wr_dq(WR_DQ),
		.wr_dm_dbi_n(WR_DM_DBI_N),
		.rd_valid(RD_VALID & dq_on),
		.rd_data(RD_DATA),
		.rd_inv(RD_INV),
		.wr_valid_q(WR_OUT_VALID),
		.wr_data_q(WR_DATA),
		.wr_be_q(WR_BE),
		.rd_valid_q(RD_OUT_VALID),
		.rd_dq_q(RD_DQ),
		.rd_dbi_n_q(RD_DBI_N)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (rst_q);

	chk_cs_masked: assert property (&cs_n_q |=> !CMD.valid) // RULE8
		else $error("command passed with chip select high");
	chk_act_row: assert property ((CMD.valid && CMD.op == udci_pkg::UDCI_C_ACT) // RULE13
		|-> CMD.row[16:14] == $past({ca_q.ras_n, ca_q.cas_n, ca_q.we_n}))
		else $error("activate row bits 16..14 wrong");
	chk_cke_gate: assert property ((any_sel && !rank_idx && !cke_q[0]) |=> !CMD.valid) // RULE2
		else $error("command accepted with cke low");
	chk_pd_kind: assert property ((pwr_q[0] == udci_pkg::UDCI_PS_ACTIVE && cke_fall[0] && !sre[0] // RULE3
		&& |open_q[0]) |=> PWR_STATE[0] == udci_pkg::UDCI_PS_ACT_PD)
		else $error("open rows did not give active power-down");
	chk_sr_ibuf: assert property ((pwr_q[0] == udci_pkg::UDCI_PS_SELF_REF) |-> IBUF_EN[0] == 4'h8) // RULE7
		else $error("buffer other than cke on in self-refresh");
	chk_pd_ibuf: assert property ((pwr_q[0] == udci_pkg::UDCI_PS_PRE_PD // RULE6
		|| pwr_q[0] == udci_pkg::UDCI_PS_ACT_PD) |-> IBUF_EN[0] == 4'he)
		else $error("power-down buffer set wrong");
	chk_sr_exit: assert property ((pwr_q[0] == udci_pkg::UDCI_PS_SELF_REF && cke_q[0]) // RULE4
		|=> PWR_STATE[0] == udci_pkg::UDCI_PS_ACTIVE)
		else $error("self-refresh exit missed");
	chk_odt_ignored: assert property ((mr1_q[0][10:8] == 3'h0) |=> !RTT_DQ_EN[0]) // RULE12
		else $error("termination on while disabled");
	chk_odt_on: assert property ((odt_q[0] && mr1_q[0][10:8] != 3'h0 && !g_rank[0].in_sr) // RULE10
		|=> RTT_DQ_EN[0])
		else $error("termination not enabled by odt");
	chk_tdqs_off: assert property (!mr1_q[0][11] |=> !RTT_TDQS_EN[0]) // RULE11 RULE17
		else $error("strobe termination without mode bit");
	chk_rdwr_flags: assert property ((CMD.valid && (CMD.op == udci_pkg::UDCI_C_RD // RULE20 RULE21
		|| CMD.op == udci_pkg::UDCI_C_WR)) |-> (CMD.auto_pre == $past(a10) && CMD.burst_chop == !$past(a12)))
		else $error("auto-precharge or burst chop wrong");
	chk_bank_sel: assert property (CMD.valid |-> (CMD.bg == $past(ca_q.bg) && CMD.ba == $past(ca_q.ba))) // RULE18 RULE19
		else $error("bank group or bank not carried");
	chk_reset_hold: assert property (disable iff (1'b0) rst_q |=> (!CMD.valid // RULE22
		&& PWR_STATE[0] == udci_pkg::UDCI_PS_ACTIVE))
		else $error("state not cleared by reset");

	cov_sr_entry: cover property (sre[0] ##1 pwr_q[0] == udci_pkg::UDCI_PS_SELF_REF);
	cov_act_pd: cover property (PWR_STATE[0] == udci_pkg::UDCI_PS_ACT_PD);
	cov_activate: cover property (CMD.valid && CMD.op == udci_pkg::UDCI_C_ACT);
	cov_rank1: cover property (CMD.valid && CMD.rank);
endmodule
`default_nettype wire

// File: shared/udci_pkg.sv
// shared constants and types for the udimm command input stage
package udci_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int UDCI_RANKS_MAX = 2;
	localparam int UDCI_BANKS = 16;
	localparam int UDCI_ADDR_W = 14;
	localparam int UDCI_LANES = 8;

	// ----------------------------------------------------------------
	// address bit positions with extra meaning
	// ----------------------------------------------------------------
	localparam int UDCI_AP_BIT = 10;
	localparam int UDCI_BC_BIT = 12;
	localparam int UDCI_MR1_TDQS_BIT = 11;
	localparam int UDCI_MR1_RTT_LO = 8;
	localparam int UDCI_MR1_RTT_HI = 10;
	localparam logic [2:0] UDCI_MR1_SEL = 3'h1;
	localparam logic [13:0] UDCI_MR1_RST = 14'h0000;

	// ----------------------------------------------------------------
	// non-activate command codes on {ras, cas, we}
	// ----------------------------------------------------------------
	localparam logic [2:0] UDCI_OP_MRS = 3'h0;
	localparam logic [2:0] UDCI_OP_REF = 3'h1;
	localparam logic [2:0] UDCI_OP_PRE = 3'h2;
	localparam logic [2:0] UDCI_OP_RFU = 3'h3;
	localparam logic [2:0] UDCI_OP_WR = 3'h4;
	localparam logic [2:0] UDCI_OP_RD = 3'h5;
	localparam logic [2:0] UDCI_OP_ZQ = 3'h6;
	localparam logic [2:0] UDCI_OP_NOP = 3'h7;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		UDCI_C_NONE = 4'h0,
		UDCI_C_ACT = 4'h1,
		UDCI_C_RD = 4'h2,
		UDCI_C_WR = 4'h3,
		UDCI_C_PRE = 4'h4,
		UDCI_C_REF = 4'h5,
		UDCI_C_MRS = 4'h6,
		UDCI_C_ZQ = 4'h7,
		UDCI_C_RFU = 4'h8
	} udci_cmd_e_t;

	typedef enum logic [1:0] {
		UDCI_PS_ACTIVE = 2'h0,
		UDCI_PS_PRE_PD = 2'h1,
		UDCI_PS_ACT_PD = 2'h2,
		UDCI_PS_SELF_REF = 2'h3
	} udci_pwr_e_t;

	typedef struct packed {
		logic cke;
		logic odt;
		logic ck;
		logic cmd;
	} udci_ibuf_t;

	typedef struct packed {
		logic act_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] bg;
		logic [1:0] ba;
		logic [UDCI_ADDR_W-1:0] addr;
	} udci_ca_t;

	typedef struct packed {
		logic valid;
		udci_cmd_e_t op;
		logic rank;
		logic [1:0] bg;
		logic [1:0] ba;
		logic [16:0] row;
		logic [9:0] col;
		logic auto_pre;
		logic burst_chop;
		logic pre_all;
		logic [2:0] mr_sel;
		logic [UDCI_ADDR_W-1:0] opcode;
	} udci_cmd_t;

endpackage

// File: design/udci_dq_lanes.sv
// write mask / bus inversion and read inversion for the byte lanes
`timescale 1ns/10ps
`default_nettype none
module udci_dq_lanes #(
	parameter int LANES = udci_pkg::UDCI_LANES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_valid,
	input wire logic dm_en,
	input wire logic dbi_en,
	input wire logic [8*LANES-1:0] wr_dq,
	input wire logic [LANES-1:0] wr_dm_dbi_n,
	input wire logic rd_valid,
	input wire logic [8*LANES-1:0] rd_data,
	input wire logic [LANES-1:0] rd_inv,
	output logic wr_valid_q,
	output logic [8*LANES-1:0] wr_data_q,
	output logic [LANES-1:0] wr_be_q,
	output logic rd_valid_q,
	output logic [8*LANES-1:0] rd_dq_q,
	output logic [LANES-1:0] rd_dbi_n_q
);
	logic [8*LANES-1:0] wr_data_d;
	logic [LANES-1:0] wr_be_d;
	logic [8*LANES-1:0] rd_dq_d;
	logic [LANES-1:0] rd_dbi_n_d;

	if (LANES < 1 || LANES > 9) begin : g_bad
		$error("udci_dq_lanes: LANES must be 1..9");
	end

	// ----------------------------------------------------------------
	// per lane; the shared pin is inversion when enabled, else a mask when dm_en is set
	// ----------------------------------------------------------------
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		wire logic wr_inv = dbi_en & ~wr_dm_dbi_n[i];
		wire logic masked = dm_en & ~dbi_en & ~wr_dm_dbi_n[i];
		wire logic rd_flip = dbi_en & rd_inv[i];
		assign wr_data_d[8*i +: 8] = wr_dq[8*i +: 8] ^ {8{wr_inv}}; // RULE16
		assign wr_be_d[i] = wr_valid & ~masked; // RULE15
		assign rd_dq_d[8*i +: 8] = rd_data[8*i +: 8] ^ {8{rd_flip}}; // RULE16
		assign rd_dbi_n_d[i] = ~rd_flip;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_valid_q <= 1'b0;
			wr_data_q <= '0;
			wr_be_q <= '0;
			rd_valid_q <= 1'b0;
			rd_dq_q <= '0;
			rd_dbi_n_q <= '1;
		end else begin
			wr_valid_q <= wr_valid;
			wr_data_q <= wr_data_d;
			wr_be_q <= wr_be_d;
			rd_valid_q <= rd_valid;
			rd_dq_q <= rd_dq_d;
			rd_dbi_n_q <= rd_dbi_n_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_mask_drop: assert property (@(posedge clk) disable iff (rst) // RULE15
		(wr_valid && dm_en && !dbi_en && !wr_dm_dbi_n[0]) |=> !wr_be_q[0])
		else $error("masked write beat kept");
	chk_dbi_invert: assert property (@(posedge clk) disable iff (rst) // RULE16
		(dbi_en && !wr_dm_dbi_n[0]) |=> (wr_data_q[7:0] == ~$past(wr_dq[7:0])))
		else $error("write data not inverted");
	cov_masked_write: cover property (@(posedge clk) disable iff (rst)
		wr_valid_q && (wr_be_q != '1));
endmodule
`default_nettype wire

// File: testbench/udci_host_model.sv
// host controller model driving command, clock-enable and termination pins
`timescale 1ns/10ps
`default_nettype none
module udci_host_model (
	input wire logic clk,
	output var logic [1:0] cke,
	output var logic [1:0] cs_n,
	output var logic [1:0] odt,
	output var udci_pkg::udci_ca_t ca
);
	// only two chip selects exist here; no third, fourth or chip id lines
	initial begin
		cke = 2'h3;
		cs_n = 2'h3;
		odt = 2'h0;
		ca = '0;
	end

	// one command cycle, then deselect; released lines show the inverse, never a stale copy
	task automatic send(input logic [1:0] sel_n, input udci_pkg::udci_ca_t v, input logic [1:0] ck);
		@(posedge clk);
		cs_n <= sel_n;
		ca <= v;
		cke <= ck;
		@(posedge clk);
		cs_n <= 2'h3;
		ca <= ~v;
	endtask

	task automatic set_odt(input logic [1:0] v);
		@(posedge clk);
		odt <= v;
	endtask
endmodule
`default_nettype wire

// File: testbench/ddr4_udimm_cmd_input_decode_tb.sv
// self-checking bench for the udimm command input stage
`timescale 1ns/10ps
`default_nettype none
module ddr4_udimm_cmd_input_decode_tb;
	logic clk, sys_rst, reset_n, dm_en, dbi_en, wr_valid, rd_valid;
	logic [1:0] cke, cs_n, odt, rtt_dq, rtt_tdqs, clk_run, md;
	logic [63:0] wr_dq, rd_data, wr_data, rd_dq, e_wr, e_rd, wd, rdt;
	logic [7:0] wr_pin, rd_inv, wr_be, rd_dbi_n, e_be, e_dbi;
	logic [15:0] pins;
	logic wr_ov, rd_ov, r, rw;
	logic [31:0] seed;
	int err_total, comparisons, i;
	udci_pkg::udci_ca_t ca, v;
	udci_pkg::udci_cmd_t cmd;
	udci_pkg::udci_pwr_e_t [1:0] pwr;
	udci_pkg::udci_ibuf_t [1:0] ibuf;
	logic [1:0][15:0] bank_open;

	udci_host_model host (.clk(clk), .cke(cke), .cs_n(cs_n), .odt(odt), .ca(ca));
	udci_cmd_input uut (.CLK(clk), .SYS_RST(sys_rst), .RESET_N(reset_n), .CKE(cke), .CS_N(cs_n),
		.ODT(odt), .CA(ca), .DM_EN(dm_en), .DBI_EN(dbi_en), .WR_VALID(wr_valid), .WR_DQ(wr_dq),
		.WR_DM_DBI_N(wr_pin), .RD_VALID(rd_valid), .RD_DATA(rd_data), .RD_INV(rd_inv), .CMD(cmd),
		.PWR_STATE(pwr), .IBUF_EN(ibuf), .CLK_RUN(clk_run), .RTT_DQ_EN(rtt_dq), .RTT_TDQS_EN(rtt_tdqs),
		.BANK_OPEN(bank_open), .WR_OUT_VALID(wr_ov), .WR_DATA(wr_data), .WR_BE(wr_be),
		.RD_OUT_VALID(rd_ov), .RD_DQ(rd_dq), .RD_DBI_N(rd_dbi_n));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic udci_pkg::udci_cmd_e_t exp_op(input logic [2:0] c);
		case (c)
			udci_pkg::UDCI_OP_MRS: return udci_pkg::UDCI_C_MRS;
			udci_pkg::UDCI_OP_REF: return udci_pkg::UDCI_C_REF;
			udci_pkg::UDCI_OP_PRE: return udci_pkg::UDCI_C_PRE;
			udci_pkg::UDCI_OP_RFU: return udci_pkg::UDCI_C_RFU;
			udci_pkg::UDCI_OP_WR: return udci_pkg::UDCI_C_WR;
			udci_pkg::UDCI_OP_RD: return udci_pkg::UDCI_C_RD;
			udci_pkg::UDCI_OP_ZQ: return udci_pkg::UDCI_C_ZQ;
			default: return udci_pkg::UDCI_C_NONE;
		endcase
	endfunction

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// command on the pins, then sample the one-cycle answer
	task automatic step(input logic [1:0] s, input udci_pkg::udci_ca_t c, input logic [1:0] k);
		host.send(s, c, k);
		@(posedge clk);
		#1;
	endtask

	task automatic pwr_chk(input udci_pkg::udci_pwr_e_t st, input logic [3:0] ib, input logic run);
		chk(pwr[0], st);
		chk(ibuf[0], ib);
		chk(clk_run[0], run);
	endtask

	task automatic tally_and_finish();
		if (err_total == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{sys_rst, reset_n, dm_en, dbi_en, wr_valid, rd_valid} = 6'h30;
		{wr_dq, rd_data, wr_pin, rd_inv, seed} = {144'h0, 32'hd3fe};
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		// internal reset drops one edge late, clock run needs one more captured cke
		repeat (3) @(posedge clk);
		#1;
		pwr_chk(udci_pkg::UDCI_PS_ACTIVE, 4'hf, 1'b1);
		chk(bank_open, 32'h0);
		for (i = 0; i < 16; i++) begin
			v = udci_pkg::udci_ca_t'(xs());
			v.act_n = 1'b0;
			r = 1'(xs());
			step(r ? 2'h1 : 2'h2, v, 2'h3);
			chk({cmd.valid, cmd.op, cmd.rank}, {1'b1, udci_pkg::UDCI_C_ACT, r});
			chk(cmd.row, {v.ras_n, v.cas_n, v.we_n, v.addr});
			chk({cmd.bg, cmd.ba}, {v.bg, v.ba});
			chk(bank_open[r][{v.bg, v.ba}], 1'b1);
		end
		for (i = 0; i < 24; i++) begin
			v = udci_pkg::udci_ca_t'(xs());
			{v.act_n, v.ras_n, v.cas_n, v.we_n} = {1'b1, i[2:0]};
			rw = (i[2:0] == udci_pkg::UDCI_OP_RD) || (i[2:0] == udci_pkg::UDCI_OP_WR);
			step(2'h2, v, 2'h3);
			chk({cmd.valid, cmd.op}, {1'b1, exp_op(i[2:0])});
			chk(cmd.auto_pre, rw & v.addr[10]);
			chk(cmd.pre_all, (i[2:0] == udci_pkg::UDCI_OP_PRE) & v.addr[10]);
			chk(cmd.burst_chop, rw & ~v.addr[12]);
			chk(cmd.mr_sel, (i[2:0] == udci_pkg::UDCI_OP_MRS) ? {v.bg[0], v.ba} : 3'h0);
			if (rw) chk(cmd.col, v.addr[9:0]);
			chk(cmd.opcode, v.addr);
		end
		v.act_n = 1'b0;
		step(2'h3, v, 2'h3);
		chk(cmd.valid, 1'b0);
		step(2'h0, v, 2'h3);
		chk({cmd.valid, cmd.rank}, 2'h2);
		// precharge-all first so the low cke sees idle banks
		{v.act_n, v.ras_n, v.cas_n, v.we_n, v.addr[10]} = 5'h15;
		step(2'h2, v, 2'h3);
		chk(bank_open[0], 16'h0);
		step(2'h3, v, 2'h2);
		pwr_chk(udci_pkg::UDCI_PS_PRE_PD, 4'he, 1'b0);
		v.act_n = 1'b0;
		step(2'h2, v, 2'h2);
		chk(cmd.valid, 1'b0);
		step(2'h3, v, 2'h3);
		pwr_chk(udci_pkg::UDCI_PS_ACTIVE, 4'hf, 1'b1);
		step(2'h2, v, 2'h3);
		step(2'h3, v, 2'h2);
		pwr_chk(udci_pkg::UDCI_PS_ACT_PD, 4'he, 1'b0);
		step(2'h3, v, 2'h3);
		{v.act_n, v.ras_n, v.cas_n, v.we_n, v.addr[10]} = 5'h15;
		step(2'h2, v, 2'h3);
		{v.ras_n, v.cas_n, v.we_n} = udci_pkg::UDCI_OP_REF;
		step(2'h2, v, 2'h2);
		pwr_chk(udci_pkg::UDCI_PS_SELF_REF, 4'h8, 1'b0);
		step(2'h3, v, 2'h3);
		pwr_chk(udci_pkg::UDCI_PS_ACTIVE, 4'hf, 1'b1);
		{v.ras_n, v.cas_n, v.we_n, v.bg, v.ba, v.addr} = {3'h0, 4'h1, 14'h0900};
		step(2'h2, v, 2'h3);
		host.set_odt(2'h1);
		repeat (2) @(posedge clk);
		#1;
		chk(rtt_dq[0], 1'b1);
		chk(rtt_tdqs[0], 1'b0);
		v.addr = 14'h0800;
		step(2'h2, v, 2'h3);
		@(posedge clk);
		#1;
		chk(rtt_dq[0], 1'b0);
		chk(rtt_tdqs[0], 1'b0);
		for (i = 0; i < 32; i++) begin
			@(posedge clk);
			md = (i < 4) ? i[1:0] : 2'(xs());
			{wd, rdt} = {xs(), xs(), xs(), xs()};
			pins = 16'(xs());
			// expectations from the drawn values, since the pins update only after this edge
			for (int l = 0; l < 8; l++) begin
				e_wr[8*l+:8] = (md[0] & ~pins[8+l]) ? ~wd[8*l+:8] : wd[8*l+:8];
				e_rd[8*l+:8] = (md[0] & pins[l]) ? ~rdt[8*l+:8] : rdt[8*l+:8];
				e_be[l] = ~(md[1] & ~md[0] & ~pins[8+l]);
				e_dbi[l] = ~(md[0] & pins[l]);
			end
			{dm_en, dbi_en} <= md;
			{wr_dq, rd_data} <= {wd, rdt};
			{wr_pin, rd_inv} <= pins;
			{wr_valid, rd_valid} <= 2'h3;
			@(posedge clk);
			#1;
			chk({wr_ov, rd_ov}, 2'h3);
			chk(wr_data, e_wr);
			chk(rd_dq, e_rd);
			chk(rd_dbi_n, e_dbi);
			chk(wr_be, e_be);
		end
		{wr_valid, rd_valid} <= 2'h0;
		v.act_n = 1'b0;
		step(2'h1, v, 2'h3);
		#5 reset_n = 1'b0;
		// the pin reaches the internal reset at one edge, the state flops at the next
		repeat (2) @(posedge clk);
		#1;
		chk(bank_open, 32'h0);
		chk({cmd.valid, clk_run}, 3'h0);
		reset_n = 1'b1;
		repeat (3) @(posedge clk);
		step(2'h2, v, 2'h3);
		chk(cmd.valid, 1'b1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
